// ==== rtl/adts_edge_detect.sv ====
// Purpose: Rising edge detector for the selected trigger level.
// Assumes: Level is synchronous to sys_clk.
// Notes:   The stored level follows the selected source every cycle.
`timescale 1ns/1ps
module adts_edge_detect (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic level,
	output logic      rise
);
	logic prev;

	// Storing the muxed level makes a source switch look like an edge.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prev <= 1'b0;
		end else begin
			prev <= level; // see (R15)
		end
	end

	assign rise = level & ~prev; // see (R15)

endmodule : adts_edge_detect

// ==== rtl/adts_pin_gate.sv ====
// Purpose: Digital input buffer gating for the six analog pins.
// Assumes: Pin levels are synchronous to sys_clk.
// Notes:   Pins six and seven have no buffer and are not handled here.
`timescale 1ns/1ps
module adts_pin_gate (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [5:0] pin_level,
	input  wire logic [5:0] buffer_off,
	output logic      [5:0] pin_read
);
	genvar i;

	generate
		for (i = 0; i < 6; i++) begin : g_pin
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					pin_read[i] <= 1'b0;
				end else begin
					pin_read[i] <= pin_level[i] & ~buffer_off[i]; // see (R9)
				end
			end
		end
	endgenerate

endmodule : adts_pin_gate

// ==== rtl/adts_trigger_select.sv ====
// Purpose: Auto-trigger source selection and analog pin input disable.
// Assumes: Event flags are synchronous levels from on-chip peripherals.
// Notes:   Conversion itself is outside; this block issues start pulses.
`timescale 1ns/1ps
// Summary of operation
// (R1) Software writes zero to reserved trigger-control bits.
// (R2) Source field acts only while auto-trigger enable is set.
// (R3) A rising edge of the selected flag starts a conversion.
// (R4) Switching from a low to a high source acts as an edge.
// (R5) Switching to free running never creates a trigger.
// (R6) Codes 0-3: free run, comparator, external 0, timer0 match A.
// (R7) Codes 4-7: timer0 overflow, timer1 match B, overflow, capture.
// (R8) Each disable bit turns off the buffer of analog pin 0-5.
// (R9) A disabled pin reads zero in the port input register.
// (R10) Software writes zero to the two upper disable bits.
// (R11) Software should disable buffers on unused analog pins.
// (R12) Analog pins 6 and 7 have no disable bits.
// (R13) Auto-trigger starts a conversion on each selected positive edge.
// (R14) Done flag sets at conversion end and drives free running.
// (R15) Selected level is stored each clock; high now, low before is edge.
// (R16) Reserved bits read zero and ignore writes.
module adts_trigger_select (
	input  wire logic                        sys_clk,
	input  wire logic                        reset,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [adts_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        comparator_flag,
	input  wire logic                        ext_irq0_flag,
	input  wire logic                        t0_match_a_flag,
	input  wire logic                        t0_overflow_flag,
	input  wire logic                        t1_match_b_flag,
	input  wire logic                        t1_overflow_flag,
	input  wire logic                        t1_capture_flag,
	input  wire logic                        conversion_finished,
	input  wire logic [5:0]                  analog_pin_level,
	output logic      [5:0]                  port_input,
	output logic      [5:0]                  analog_pin_buffer_off,
	output logic                             conversion_start
);
	logic [7:0] conversion_trigger_control;
	logic [7:0] analog_pin_input_disable;
	logic       converter_enable;
	logic       auto_trigger_enable;
	logic       conversion_done_flag;
	logic [2:0] trigger_source_select;
	logic       sel_level;
	logic       trig_rise;
	logic       acc;
	logic       wr;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge where the master sees ack, so both agree.
	assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[9:2];
	assign wbyte = wb_dat_i[7:0];
	assign trigger_source_select =
		conversion_trigger_control[adts_pkg::SRC_LSB +: adts_pkg::SRC_W];

	// Ack one cycle after the request, and drop it the next cycle.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= acc;
		end
	end

	// Reserved bits are masked on write so they stay zero.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			conversion_trigger_control <= adts_pkg::RST_TRIG_CTRL;
			analog_pin_input_disable <= adts_pkg::RST_PIN_DIS;
		end else if (wr) begin
			if (hit(idx, adts_pkg::IDX_TRIG_CTRL)) begin
				conversion_trigger_control <=
					wbyte & adts_pkg::MASK_TRIG_CTRL; // see (R16)
			end
			if (hit(idx, adts_pkg::IDX_PIN_DIS)) begin
				analog_pin_input_disable <=
					wbyte & adts_pkg::MASK_PIN_DIS; // see (R12)
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			converter_enable <= 1'b0;
			auto_trigger_enable <= 1'b0;
		end else if (wr && hit(idx, adts_pkg::IDX_CONV_CTRL)) begin
			converter_enable <= wbyte[adts_pkg::CC_EN_BIT];
			auto_trigger_enable <= wbyte[adts_pkg::CC_ATE_BIT];
		end
	end

	// A new completion wins over a write-one clear in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			conversion_done_flag <= 1'b0;
		end else if (conversion_finished) begin
			conversion_done_flag <= 1'b1; // see (R14)
		end else if (wr && hit(idx, adts_pkg::IDX_CONV_CTRL)
			&& wbyte[adts_pkg::CC_DONE_BIT]) begin
			conversion_done_flag <= 1'b0;
		end
	end

	// Free running is forced low so switching to it cannot make an edge.
	always_comb begin
		case (trigger_source_select) // see (R6) see (R7)
			adts_pkg::SRC_FREE:    sel_level = 1'b0; // see (R5)
			adts_pkg::SRC_COMP:    sel_level = comparator_flag;
			adts_pkg::SRC_EXT0:    sel_level = ext_irq0_flag;
			adts_pkg::SRC_T0_CMPA: sel_level = t0_match_a_flag;
			adts_pkg::SRC_T0_OVF:  sel_level = t0_overflow_flag;
			adts_pkg::SRC_T1_CMPB: sel_level = t1_match_b_flag;
			adts_pkg::SRC_T1_OVF:  sel_level = t1_overflow_flag;
			adts_pkg::SRC_T1_CAPT: sel_level = t1_capture_flag;
			default:               sel_level = 1'b0;
		endcase
	end

	adts_edge_detect u_edge (
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (sel_level),
		.rise    (trig_rise)
	);

	// Free running restarts on each finished conversion instead of an edge.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			conversion_start <= 1'b0;
		end else if (!converter_enable || !auto_trigger_enable) begin
			conversion_start <= 1'b0; // see (R2)
		end else if (trigger_source_select == adts_pkg::SRC_FREE) begin
			conversion_start <= conversion_finished; // see (R14)
		end else begin
			conversion_start <= trig_rise; // see (R3) see (R4) see (R13)
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			analog_pin_buffer_off <= 6'h00;
		end else begin
			analog_pin_buffer_off <=
				analog_pin_input_disable[adts_pkg::PIN_W-1:0]; // see (R8)
		end
	end

	adts_pin_gate u_gate (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.pin_level  (analog_pin_level),
		.buffer_off (analog_pin_input_disable[adts_pkg::PIN_W-1:0]),
		.pin_read   (port_input)
	);

	always_comb begin
		next_rdata = 8'h00;
		case (idx)
			adts_pkg::IDX_TRIG_CTRL: next_rdata = conversion_trigger_control;
			adts_pkg::IDX_PIN_DIS:   next_rdata = analog_pin_input_disable;
			adts_pkg::IDX_CONV_CTRL: next_rdata = {5'h00,
				conversion_done_flag, auto_trigger_enable, converter_enable};
			adts_pkg::IDX_STATUS:    next_rdata = {7'h00, sel_level};
			default:                 next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (acc && !wb_we_i) begin
			wb_dat_o <= {24'h00_0000, next_rdata};
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	property p_free_no_start;
		@(posedge sys_clk) disable iff (reset)
		$changed(trigger_source_select) &&
		trigger_source_select == adts_pkg::SRC_FREE && !conversion_finished
		|=> !conversion_start;
	endproperty
	a_free_no_start: assert property (p_free_no_start) // see (R5)
		else $error("Switch to free running made a start.");

	property p_disabled_quiet;
		@(posedge sys_clk) disable iff (reset)
		!auto_trigger_enable |=> !conversion_start;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) // see (R2)
		else $error("Start while auto trigger is off.");

	sequence s_rise;
		!sel_level ##1 sel_level;
	endsequence
	property p_rise_start;
		@(posedge sys_clk) disable iff (reset)
		(s_rise ##0 (converter_enable && auto_trigger_enable &&
		trigger_source_select != adts_pkg::SRC_FREE)) |=> conversion_start;
	endproperty
	a_rise_start: assert property (p_rise_start) // see (R3)
		else $error("Rising trigger gave no start.");

	property p_pin_zero;
		@(posedge sys_clk) disable iff (reset)
		analog_pin_input_disable[0] |=> port_input[0] == 1'b0;
	endproperty
	a_pin_zero: assert property (p_pin_zero) // see (R9)
		else $error("Disabled pin read non-zero.");

	property p_reserved;
		@(posedge sys_clk) disable iff (reset)
		conversion_trigger_control[7:3] == 5'h00 &&
		analog_pin_input_disable[7:6] == 2'h0;
	endproperty
	a_reserved: assert property (p_reserved) // see (R16)
		else $error("Reserved bits became set.");

	property p_buf_off;
		@(posedge sys_clk) disable iff (reset)
		1'b1 |=> analog_pin_buffer_off == $past(analog_pin_input_disable[5:0]);
	endproperty
	a_buf_off: assert property (p_buf_off) // see (R8)
		else $error("Buffer off does not follow disable bits.");

	property p_free_run;
		@(posedge sys_clk) disable iff (reset)
		conversion_finished && converter_enable && auto_trigger_enable &&
		trigger_source_select == adts_pkg::SRC_FREE |=> conversion_start;
	endproperty
	a_free_run: assert property (p_free_run) // see (R14)
		else $error("Free running gave no restart.");

	property p_done_set;
		@(posedge sys_clk) disable iff (reset)
		conversion_finished |=> conversion_done_flag;
	endproperty
	a_done_set: assert property (p_done_set) // see (R14)
		else $error("Done flag not set.");

	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	property p_ack_answer;
		@(posedge sys_clk) disable iff (reset)
		s_bus_req |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("Bus request was not acknowledged.");

	property p_ack_pulse;
		@(posedge sys_clk) disable iff (reset)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("Ack stood longer than one cycle.");

	property p_rdata_idle;
		@(posedge sys_clk) disable iff (reset)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("Read data not zero outside ack.");

	property p_rdata_upper;
		@(posedge sys_clk) disable iff (reset)
		wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper) // see (R16)
		else $error("Upper read data bits not zero.");

	property p_trig_write;
		@(posedge sys_clk) disable iff (reset)
		wr && hit(idx, adts_pkg::IDX_TRIG_CTRL) |=>
		conversion_trigger_control ==
		($past(wbyte) & adts_pkg::MASK_TRIG_CTRL);
	endproperty
	a_trig_write: assert property (p_trig_write) // see (R16)
		else $error("Trigger control write did not land.");

	property p_dis_write;
		@(posedge sys_clk) disable iff (reset)
		wr && hit(idx, adts_pkg::IDX_PIN_DIS) |=>
		analog_pin_input_disable ==
		($past(wbyte) & adts_pkg::MASK_PIN_DIS);
	endproperty
	a_dis_write: assert property (p_dis_write) // see (R12)
		else $error("Input disable write did not land.");

	property p_regs_hold;
		@(posedge sys_clk) disable iff (reset)
		!wr |=> $stable(conversion_trigger_control) &&
		$stable(analog_pin_input_disable);
	endproperty
	a_regs_hold: assert property (p_regs_hold) // see (R16)
		else $error("Register changed without a write.");

	sequence s_armed;
		converter_enable && auto_trigger_enable &&
		trigger_source_select != adts_pkg::SRC_FREE;
	endsequence
	property p_switch_start;
		@(posedge sys_clk) disable iff (reset)
		s_armed ##0 ($changed(trigger_source_select) && sel_level &&
		!$past(sel_level)) |=> conversion_start;
	endproperty
	a_switch_start: assert property (p_switch_start) // see (R4)
		else $error("Switch to a set flag gave no start.");

	property p_conv_off_quiet;
		@(posedge sys_clk) disable iff (reset)
		!converter_enable |=> !conversion_start;
	endproperty
	a_conv_off_quiet: assert property (p_conv_off_quiet) // see (R2)
		else $error("Start while converter is off.");

	property p_start_cause;
		@(posedge sys_clk) disable iff (reset)
		conversion_start |-> $past(conversion_finished) ||
		($past(sel_level) && !$past(sel_level, 2));
	endproperty
	a_start_cause: assert property (p_start_cause) // see (R3)
		else $error("Start without an edge or a completion.");

	property p_pin_pass;
		@(posedge sys_clk) disable iff (reset)
		1'b1 |=> port_input ==
		($past(analog_pin_level) & ~$past(analog_pin_input_disable[5:0]));
	endproperty
	a_pin_pass: assert property (p_pin_pass) // see (R9)
		else $error("Port input does not follow enabled pins.");

	property p_done_clear;
		@(posedge sys_clk) disable iff (reset)
		wr && hit(idx, adts_pkg::IDX_CONV_CTRL) &&
		wbyte[adts_pkg::CC_DONE_BIT] && !conversion_finished
		|=> !conversion_done_flag;
	endproperty
	a_done_clear: assert property (p_done_clear) // see (R14)
		else $error("Done flag not cleared by write.");

endmodule : adts_trigger_select

// ==== shared/adts_pkg.sv ====
// Purpose: Constants shared by the conversion trigger select block.
// Assumes: Classic Wishbone register access with 32-bit data words.
// Notes:   Byte addresses are four times the printed register index.
package adts_pkg;

	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_TRIG_CTRL = 8'h7B;
	localparam logic [7:0] IDX_PIN_DIS = 8'h7E;
	localparam logic [7:0] IDX_CONV_CTRL = 8'hF0;
	localparam logic [7:0] IDX_STATUS = 8'hF1;
	localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
	localparam logic [7:0] RST_PIN_DIS = 8'h00;
	localparam logic [7:0] MASK_TRIG_CTRL = 8'h07;
	localparam logic [7:0] MASK_PIN_DIS = 8'h3F;
	localparam int SRC_LSB = 0;
	localparam int SRC_W = 3;
	localparam int PIN_W = 6;
	localparam int CC_EN_BIT = 0;
	localparam int CC_ATE_BIT = 1;
	localparam int CC_DONE_BIT = 2;
	localparam logic [2:0] SRC_FREE = 3'h0;
	localparam logic [2:0] SRC_COMP = 3'h1;
	localparam logic [2:0] SRC_EXT0 = 3'h2;
	localparam logic [2:0] SRC_T0_CMPA = 3'h3;
	localparam logic [2:0] SRC_T0_OVF = 3'h4;
	localparam logic [2:0] SRC_T1_CMPB = 3'h5;
	localparam logic [2:0] SRC_T1_OVF = 3'h6;
	localparam logic [2:0] SRC_T1_CAPT = 3'h7;

endpackage : adts_pkg

// ==== verification/adts_flag_source.sv ====
// Purpose: Model of the on-chip event flags feeding the trigger selector.
// Assumes: Flags are synchronous levels that may change on every cycle.
// Notes:   Levels follow the bench's request one edge later.
`timescale 1ns/1ps
module adts_flag_source (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [7:0] want,
	output logic      [6:0] flags,
	output logic            finished
);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flags    <= 7'h00;
			finished <= 1'b0;
		end else begin
			// Flags toggle freely, so every kind of edge can be reached.
			flags    <= want[6:0];
			// Completion is a pulse, never two cycles in a row.
			finished <= want[7] & ~finished;
		end
	end
endmodule : adts_flag_source

// ==== verification/adts_trigger_select_tb.sv ====
// Purpose: Self-checking bench for the trigger select block.
// Assumes: Register writes take effect at the edge where ack is sampled.
// Notes:   A cycle model predicts start pulses and pin reads every cycle.
`timescale 1ns/1ps
`define CHK(n, a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %s expected %0h seen %0h", n, b, a); end end
module adts_trigger_select_tb;
	logic        sys_clk, reset, cyc, stb, we, ack, start, fin;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, q;
	logic [7:0]  want;
	logic [6:0]  flags;
	logic [5:0]  pins, port_rd, buf_off, dis;
	logic [2:0]  src;
	logic        en, ate, prev, lvl, exp_start;
	logic [5:0]  exp_port, exp_buf;
	integer      seed = 32'hada4427e;
	int          bad_count, compares, cycles, k;
	adts_flag_source i_adts_flag_source (.sys_clk(sys_clk), .reset(reset),
		.want(want), .flags(flags), .finished(fin));
	adts_trigger_select i_adts_trigger_select (.sys_clk(sys_clk),
		.reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .comparator_flag(flags[0]),
		.ext_irq0_flag(flags[1]), .t0_match_a_flag(flags[2]),
		.t0_overflow_flag(flags[3]), .t1_match_b_flag(flags[4]),
		.t1_overflow_flag(flags[5]), .t1_capture_flag(flags[6]),
		.conversion_finished(fin), .analog_pin_level(pins),
		.port_input(port_rd), .analog_pin_buffer_off(buf_off),
		.conversion_start(start));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic end_sim;
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	// Cycle model; it reads inputs before this edge's updates land.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			end_sim();
		end
		if (reset) begin
			{src, en, ate, dis, prev, exp_start, exp_port, exp_buf} = '0;
		end else begin
			lvl = (src == 3'h0) ? 1'b0 : flags[src - 3'h1];
			// Free running follows completion only, never a switch.
			exp_start = en & ate & ((src == 3'h0) ? fin : lvl & ~prev);
			prev = lvl;
			exp_port = pins & ~dis;
			// Buffer state shows the disable bits held before this edge.
			exp_buf = dis;
			if (cyc & stb & we & ack & sel[0]) begin
				case (adr[9:2])
					adts_pkg::IDX_TRIG_CTRL: src = dat[2:0];
					adts_pkg::IDX_PIN_DIS: dis = dat[5:0];
					adts_pkg::IDX_CONV_CTRL: {ate, en} = dat[1:0];
					default: ;
				endcase
			end
		end
	end
	always @(negedge sys_clk) begin
		if (!reset) begin
			`CHK("start", start, exp_start)
			`CHK("port_input", port_rd, exp_port)
			`CHK("buffer_off", buf_off, exp_buf)
		end
	end
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] d, output logic [31:0] r);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h000000, d};
		sel <= 4'hF;
		do @(posedge sys_clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic run(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			want <= 8'($random(seed));
			pins <= 6'($random(seed));
		end
	endtask : run
	initial begin
		{cyc, stb, we, adr, sel, dat, want, pins} = '0;
		{bad_count, compares, cycles} = '0;
		reset = 1'b1;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		bus(1'b0, adts_pkg::IDX_TRIG_CTRL, 8'h00, q);
		`CHK("trig reset", q, 32'h00000000)
		bus(1'b0, adts_pkg::IDX_PIN_DIS, 8'h00, q);
		`CHK("dis reset", q, 32'h00000000)
		// Reserved bits are written as ones on purpose here.
		bus(1'b1, adts_pkg::IDX_TRIG_CTRL, 8'hFF, q);
		bus(1'b0, adts_pkg::IDX_TRIG_CTRL, 8'h00, q);
		`CHK("trig mask", q, 32'h00000007)
		bus(1'b1, adts_pkg::IDX_PIN_DIS, 8'hFF, q);
		bus(1'b0, adts_pkg::IDX_PIN_DIS, 8'h00, q);
		`CHK("dis mask", q, 32'h0000003F)
		bus(1'b0, 8'h20, 8'h00, q);
		`CHK("unmapped", q, 32'h00000000)
		for (k = 0; k < 32; k++) begin
			// Cycle through enable pairs and every source code.
			bus(1'b1, adts_pkg::IDX_CONV_CTRL,
				(k < 16) ? 8'h03 : {6'h00, k[3], k[0]}, q);
			bus(1'b1, adts_pkg::IDX_TRIG_CTRL, {5'h00, k[2:0]}, q);
			bus(1'b1, adts_pkg::IDX_PIN_DIS, 8'($random(seed)) & 8'h3F,
				q);
			run(30);
		end
		end_sim();
	end
endmodule : adts_trigger_select_tb
